/* File: hw/i2ccs_pkg.sv */
package i2ccs_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [3:0]  ADDR_CONTROL  = 4'h0;
  localparam logic [3:0]  ADDR_STATUS   = 4'h1;
  localparam logic [3:0]  ADDR_RECEIVE  = 4'h2;
  localparam logic [3:0]  ADDR_TRANSMIT = 4'h3;
  localparam logic [3:0]  ADDR_OWN_ADDR = 4'h4;
  localparam logic [3:0]  ADDR_IRQ_STAT = 4'h5;
  localparam logic [3:0]  ADDR_IRQ_MASK = 4'h6;

  // ----------------------------------------------------------------
  // control bit positions
  // ----------------------------------------------------------------
  localparam int BIT_ENABLE    = 15;
  localparam int BIT_IDLE_HALT = 13;
  localparam int BIT_RELEASE   = 12;
  localparam int BIT_ACK_ALL   = 11;
  localparam int BIT_WIDE_ADDR = 10;
  localparam int BIT_GC_EN     = 7;
  localparam int BIT_STRETCH   = 6;
  localparam int BIT_ACK_VALUE = 5;
  localparam int BIT_ACK_SEQ   = 4;
  localparam int BIT_RCV_EN    = 3;
  localparam int BIT_STOP_EN   = 2;
  localparam int BIT_RESTART   = 1;
  localparam int BIT_START_EN  = 0;

  // status bit positions
  localparam int BIT_START_SEEN = 3;
  localparam int BIT_DIRECTION  = 2;
  localparam int BIT_RX_FULL    = 1;
  localparam int BIT_TX_FULL    = 0;

  // interrupt bit positions
  localparam int IRQ_GENCALL = 0;
  localparam int IRQ_RX_BYTE = 1;
  localparam int IRQ_TX_DONE = 2;
  localparam int IRQ_STOP    = 3;

  // ----------------------------------------------------------------
  // reset values and fixed bus constants
  // ----------------------------------------------------------------
  localparam logic [15:0] RESET_CONTROL  = 16'h1000;
  localparam logic [15:0] RESET_STATUS   = 16'h0000;
  localparam logic [9:0]  RESET_OWN_ADDR = 10'h000;
  localparam logic [7:0]  GENCALL_ADDR   = 8'h00;
  localparam logic [3:0]  BIT_COUNT_LAST = 4'h8;

  typedef enum logic [2:0] {
    I2CCS_IDLE  = 3'b000,
    I2CCS_ADDR  = 3'b001,
    I2CCS_ADDR2 = 3'b011,
    I2CCS_ACK   = 3'b010,
    I2CCS_DATA  = 3'b110,
    I2CCS_DACK  = 3'b111,
    I2CCS_SKIP  = 3'b101
  } i2ccs_state_e;

  typedef struct packed {
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } i2ccs_bus_s;

  typedef struct packed {
    logic scl_o;
    logic scl_oe_n;
    logic sda_o;
    logic sda_oe_n;
  } i2ccs_pins_s;

endpackage

/* File: hw/i2ccs_top.sv */
// Design decisions made here: the address map and the plain strobed port.
`timescale 1ns/100ps
// Notes on behaviour
// - the enable bit hands both serial pins to the block; clear, port owns them
// - as slave, release bit 1 frees the clock line; 0 holds it low in a transfer while stretching or transmitting
// - without stretching software only sets release; hardware clears it at transmit start
// - with stretching, hardware also clears release at the end of each received byte
// - the acknowledge-all bit makes the slave acknowledge every address
// - the wide-address bit selects a 10-bit own address, else 7-bit
// - with general call enabled, the general call address raises an interrupt
// - the stretch enable bit permits forced or receive-triggered stretching
// - start-seen is set by start or repeated start and cleared by stop
// - after an address byte the direction bit shows read as 1, write as 0
// - receive-full sets on a received byte and clears on a read of it
// - transmit-full sets on a transmit write and clears when the byte has gone
module i2ccs_top
(
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire i2ccs_pkg::i2ccs_bus_s bus,
  input  wire logic                  device_idle,
  input  wire logic                  scl_i,
  input  wire logic                  sda_i,
  output logic [15:0]                rdata,
  output i2ccs_pkg::i2ccs_pins_s     pins,
  output logic                       port_owns_pins,
  output logic                       irq
);
  import i2ccs_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0]   scl_sync;
    logic [1:0]   sda_sync;
    logic         scl_q;
    logic         sda_q;
    logic [15:0]  control;
    logic [15:0]  status;
    logic [7:0]   rx_hold;
    logic [7:0]   tx_hold;
    logic [9:0]   own_addr;
    logic [3:0]   irq_stat;
    logic [3:0]   irq_mask;
    i2ccs_state_e state;
    logic [7:0]   shift;
    logic [3:0]   bits;
    logic         gencall;
    logic         wide_pend;
    logic         rx_pending;
    logic [15:0]  rdata;
    i2ccs_pins_s  pins;
    logic         port_owns;
    logic         irq;
  } i2ccs_reg_s;

  i2ccs_reg_s r;
  i2ccs_reg_s next_r;

  function automatic logic addr_match(input logic [7:0] b,
                                      input logic [9:0] own,
                                      input logic       wide);
    addr_match = wide ? (b[7:3] == 5'b11110 && b[2:1] == own[9:8])
                      : (b[7:1] == own[6:0]);
  endfunction

  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  logic running;

  assign scl_rise   = r.scl_sync[1] & ~r.scl_q;
  assign scl_fall   = ~r.scl_sync[1] & r.scl_q;
  assign start_cond = r.scl_sync[1] & r.scl_q & r.sda_q & ~r.sda_sync[1];
  assign stop_cond  = r.scl_sync[1] & r.scl_q & ~r.sda_q & r.sda_sync[1];

  always_comb
  begin
    logic       drive_sda;
    logic       hold_scl;
    logic [7:0] byte_in;
    logic       match;
    logic       rd_rx;
    drive_sda = 1'b0;
    hold_scl  = 1'b0;
    byte_in   = {r.shift[6:0], r.sda_q};
    match     = 1'b0;
    rd_rx     = bus.rd && bus.addr == ADDR_RECEIVE;
    next_r    = r;
    next_r.scl_sync = {r.scl_sync[0], scl_i};
    next_r.sda_sync = {r.sda_sync[0], sda_i};
    next_r.scl_q    = r.scl_sync[1];
    next_r.sda_q    = r.sda_sync[1];
    // idle halt freezes the bus engine
    // idle halt gate
    running = r.control[BIT_ENABLE] &&
              !(r.control[BIT_IDLE_HALT] && device_idle);

    // ----------------------------------------------------------------
    // register writes and reads
    // ----------------------------------------------------------------
    if (bus.wr)
    begin
      case (bus.addr)
        ADDR_CONTROL:
        begin
          next_r.control = bus.wdata & 16'hbcff;
          if (!r.control[BIT_STRETCH] && !bus.wdata[BIT_RELEASE])
            next_r.control[BIT_RELEASE] = r.control[BIT_RELEASE];
        end
        ADDR_TRANSMIT:
        begin
          next_r.tx_hold = bus.wdata[7:0];
          next_r.status[BIT_TX_FULL] = 1'b1;
        end
        ADDR_OWN_ADDR: next_r.own_addr = bus.wdata[9:0];
        ADDR_IRQ_MASK: next_r.irq_mask = bus.wdata[3:0];
        default: ;
      endcase
    end
    next_r.rdata = 16'h0000;
    if (bus.rd)
    begin
      case (bus.addr)
        ADDR_CONTROL:  next_r.rdata = r.control;
        ADDR_STATUS:   next_r.rdata = r.status;
        ADDR_RECEIVE:  next_r.rdata = {8'h00, r.rx_hold};
        ADDR_TRANSMIT: next_r.rdata = {8'h00, r.tx_hold};
        ADDR_OWN_ADDR: next_r.rdata = {6'h00, r.own_addr};
        ADDR_IRQ_STAT: next_r.rdata = {12'h000, r.irq_stat};
        ADDR_IRQ_MASK: next_r.rdata = {12'h000, r.irq_mask};
        default:       next_r.rdata = 16'h0000;
      endcase
    end
    if (rd_rx)
      next_r.status[BIT_RX_FULL] = 1'b0;
    // read of the sticky status clears it; events below win
    if (bus.rd && bus.addr == ADDR_IRQ_STAT)
      next_r.irq_stat = 4'h0;

    // ----------------------------------------------------------------
    // bus engine
    // ----------------------------------------------------------------
    if (!r.control[BIT_ENABLE])
      next_r.state = I2CCS_IDLE;
    else if (running)
    begin
      // master sequences are not modelled; the request retires at once
      // sequence self clear
      next_r.control[4:0] = 5'h00;
      if (start_cond)
      begin
        next_r.status[BIT_START_SEEN] = 1'b1;
        next_r.state = I2CCS_ADDR;
        next_r.bits  = 4'h0;
        next_r.wide_pend = 1'b0;
      end
      else if (stop_cond)
      begin
        next_r.status[BIT_START_SEEN] = 1'b0;
        next_r.irq_stat[IRQ_STOP] = 1'b1;
        next_r.state = I2CCS_IDLE;
      end
      else if (scl_rise && r.state inside {I2CCS_ADDR, I2CCS_ADDR2,
                                           I2CCS_DATA})
      begin
        // an outgoing bit must stand while the clock is high
        if (!(r.state == I2CCS_DATA && r.status[BIT_DIRECTION]))
          next_r.shift = byte_in;
        next_r.bits  = r.bits + 4'h1;
      end
      else if (scl_fall)
      begin
        case (r.state)
          I2CCS_ADDR, I2CCS_ADDR2:
            if (r.bits == BIT_COUNT_LAST)
            begin
              next_r.bits = 4'h0;
              next_r.gencall = r.state == I2CCS_ADDR &&
                               r.control[BIT_GC_EN] &&
                               r.shift == GENCALL_ADDR;
              match = addr_match(r.shift, r.own_addr,
                                 r.control[BIT_WIDE_ADDR]);
              if (r.state == I2CCS_ADDR2)
                match = r.shift == r.own_addr[7:0];
              if (r.control[BIT_ACK_ALL])
                match = 1'b1;
              if (r.state == I2CCS_ADDR && r.control[BIT_WIDE_ADDR] &&
                  match && !r.shift[0] && !r.control[BIT_ACK_ALL])
              begin
                // the first byte of a wide address is acknowledged too
                next_r.state     = I2CCS_ACK;
                next_r.wide_pend = 1'b1;
              end
              else if (match || next_r.gencall)
              begin
                next_r.state = I2CCS_ACK;
                if (next_r.gencall)
                  next_r.irq_stat[IRQ_GENCALL] = 1'b1;
                // direction; the low address byte carries none
                next_r.status[BIT_DIRECTION] = r.state == I2CCS_ADDR &&
                                               r.shift[0];
              end
              else
                next_r.state = I2CCS_SKIP;
            end
          I2CCS_ACK:
          begin
            next_r.state = I2CCS_DATA;
            if (r.wide_pend)
            begin
              next_r.state     = I2CCS_ADDR2;
              next_r.wide_pend = 1'b0;
            end
            else if (r.status[BIT_DIRECTION])
            begin
              next_r.shift = r.tx_hold;
              next_r.control[BIT_RELEASE] = 1'b0;
            end
          end
          I2CCS_DATA:
            if (r.bits == BIT_COUNT_LAST)
            begin
              next_r.bits  = 4'h0;
              next_r.state = I2CCS_DACK;
              if (r.status[BIT_DIRECTION])
              begin
                // clear on completion; a new write wins
                if (!(bus.wr && bus.addr == ADDR_TRANSMIT))
                  next_r.status[BIT_TX_FULL] = 1'b0;
                next_r.irq_stat[IRQ_TX_DONE] = 1'b1;
              end
              else
              begin
                next_r.rx_hold = r.shift;
                next_r.status[BIT_RX_FULL] = 1'b1;
                next_r.irq_stat[IRQ_RX_BYTE] = 1'b1;
              end
            end
            else if (r.status[BIT_DIRECTION])
              next_r.shift = {r.shift[6:0], 1'b0};
          I2CCS_DACK:
            if (r.status[BIT_DIRECTION] && r.sda_q)
              next_r.state = I2CCS_SKIP;
            else
            begin
              // the next byte follows straight after the acknowledge
              next_r.state = I2CCS_DATA;
              if (r.status[BIT_DIRECTION])
              begin
                next_r.shift = r.tx_hold;
                next_r.control[BIT_RELEASE] = 1'b0;
              end
              else if (r.control[BIT_STRETCH])
                next_r.control[BIT_RELEASE] = 1'b0;
            end
          default: ;
        endcase
      end
    end

    // ----------------------------------------------------------------
    // pins and interrupt
    // ----------------------------------------------------------------
    case (r.state)
      I2CCS_ACK:  drive_sda = 1'b1;
      I2CCS_DACK: drive_sda = !r.status[BIT_DIRECTION] &&
                              !r.control[BIT_ACK_VALUE];
      I2CCS_DATA: drive_sda = r.status[BIT_DIRECTION] && !r.shift[7];
      default:    drive_sda = 1'b0;
    endcase
    hold_scl = r.state != I2CCS_IDLE && r.state != I2CCS_SKIP &&
               !r.control[BIT_RELEASE] &&
               (r.control[BIT_STRETCH] || r.status[BIT_DIRECTION]);
    next_r.port_owns      = !r.control[BIT_ENABLE];
    next_r.pins.sda_o     = 1'b0;
    next_r.pins.scl_o     = 1'b0;
    next_r.pins.sda_oe_n  = !(r.control[BIT_ENABLE] && drive_sda);
    next_r.pins.scl_oe_n  = !(r.control[BIT_ENABLE] && hold_scl);
    next_r.irq            = |(next_r.irq_stat & r.irq_mask);
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      r           <= '0;
      r.scl_sync  <= 2'b11;
      r.sda_sync  <= 2'b11;
      r.scl_q     <= 1'b1;
      r.sda_q     <= 1'b1;
      r.control   <= RESET_CONTROL;
      r.status    <= RESET_STATUS;
      r.own_addr  <= RESET_OWN_ADDR;
      r.state     <= I2CCS_IDLE;
      r.pins      <= 4'b0101;
      r.port_owns <= 1'b1;
    end
    else
      r <= next_r;
  end

  assign rdata          = r.rdata;
  assign pins           = r.pins;
  assign port_owns_pins = r.port_owns;
  assign irq            = r.irq;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_pins_released: assert property
    (!r.control[BIT_ENABLE] |=> pins.scl_oe_n && pins.sda_oe_n)
    else $error("pins driven while disabled");
  a_port_owner: assert property
    (port_owns_pins == !$past(r.control[BIT_ENABLE]))
    else $error("port ownership wrong");
  a_release_frees: assert property
    (r.control[BIT_RELEASE] |=> pins.scl_oe_n)
    else $error("clock held while released");
  a_start_sets: assert property
    (running && start_cond |=> r.status[BIT_START_SEEN])
    else $error("start not recorded");
  a_stop_clears: assert property
    (running && stop_cond && !start_cond |=> !r.status[BIT_START_SEEN])
    else $error("stop did not clear start");
  a_rx_read_clears: assert property
    (bus.rd && bus.addr == ADDR_RECEIVE && !(r.state == I2CCS_DATA &&
     scl_fall) |=> !r.status[BIT_RX_FULL])
    else $error("receive flag not cleared");
  a_tx_write_sets: assert property
    (bus.wr && bus.addr == ADDR_TRANSMIT |=> r.status[BIT_TX_FULL])
    else $error("transmit flag not set");
  a_seq_clears: assert property
    (running |=> r.control[4:0] == 5'h00)
    else $error("sequence bits not cleared");
  a_irq_follows: assert property
    (irq == |($past(next_r.irq_stat) & $past(r.irq_mask)))
    else $error("interrupt level wrong");

  c_start_seen: cover property (running && start_cond);
  c_byte_rx:    cover property (r.status[BIT_RX_FULL]);
  c_gencall:    cover property (r.irq_stat[IRQ_GENCALL]);
  c_stretch:    cover property (!pins.scl_oe_n);
endmodule

/* File: testbench/i2ccs_master_model.sv */
`timescale 1ns/100ps
// ----------------------------------------
// bus master on the far side of the wire
// ----------------------------------------
module i2ccs_master_model
(
  input  wire logic scl_oe_n,
  input  wire logic sda_oe_n,
  output logic      scl_line,
  output logic      sda_line
);
  logic scl_rel = 1'b1;
  logic sda_rel = 1'b1;
  int   fails   = 0;
  // pull-ups: a released line reads high, never the last value
  assign scl_line = scl_rel & scl_oe_n;
  assign sda_line = sda_rel & sda_oe_n;
  task automatic clk_high();
    int n;
    n = 0;
    scl_rel = 1'b1;
    while (!scl_line && n < 2000)
    begin
      #4;
      n++;
    end
    if (n >= 2000)
      fails++;
    #8;
  endtask
  // long low phase, since the slave answers a few cycles after a fall
  task automatic bit_io(input logic b, output logic s);
    #10 sda_rel = b;
    #14;
    clk_high();
    s = sda_line;
    scl_rel = 1'b0;
  endtask
  task automatic start();
    scl_rel = 1'b1;
    sda_rel = 1'b1;
    #16 sda_rel = 1'b0;
    #16 scl_rel = 1'b0;
  endtask
  task automatic stop();
    #10 sda_rel = 1'b0;
    #14;
    clk_high();
    #8 sda_rel = 1'b1;
    #16;
  endtask
  task automatic send(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], s);
    bit_io(1'b1, ack);
  endtask
  task automatic recv(input logic nack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_io(1'b1, d[i]);
    bit_io(nack, s);
  endtask
endmodule

/* File: testbench/i2c_control_status_tb.sv */
`timescale 1ns/100ps
module i2c_control_status_tb;
  import i2ccs_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  i2ccs_bus_s bus = '0;
  logic device_idle = 1'b0;
  logic [15:0] rdata;
  i2ccs_pins_s pins;
  logic port_owns_pins;
  logic irq;
  logic scl_line;
  logic sda_line;
  int errors = 0;
  int checks_done = 0;
  int cyc = 0;
  logic [15:0] ctl;
  logic [15:0] v;
  logic [9:0] oa;
  logic [7:0] d;
  logic [7:0] got;
  logic a;
  always #2 clk = ~clk;
  i2ccs_top dut_u (.clk(clk), .rst_n(rst_n), .bus(bus),
    .device_idle(device_idle), .scl_i(scl_line), .sda_i(sda_line),
    .rdata(rdata), .pins(pins), .port_owns_pins(port_owns_pins),
    .irq(irq));
  i2ccs_master_model m_u (.scl_oe_n(pins.scl_oe_n),
    .sda_oe_n(pins.sda_oe_n), .scl_line(scl_line), .sda_line(sda_line));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic report_and_stop();
    if (errors == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] ad, input logic [15:0] wd);
    @(posedge clk) bus <= '{addr:ad, wdata:wd, wr:1'b1, rd:1'b0};
    @(posedge clk) bus <= '0;
  endtask
  task automatic rd(input logic [3:0] ad, output logic [15:0] q);
    @(posedge clk) bus <= '{addr:ad, wdata:16'h0, wr:1'b0, rd:1'b1};
    @(posedge clk) bus <= '0;
    #1 q = rdata;
  endtask
  task automatic setc(input logic [15:0] c);
    ctl = c;
    wr(ADDR_CONTROL, c);
  endtask
  // one master write of a data byte to the own 7-bit address
  task automatic write_xfer(input logic [7:0] dd);
    m_u.start();
    rd(ADDR_STATUS, v);
    chk(v[BIT_START_SEEN], 1'b1);
    m_u.send({oa[6:0], 1'b0}, a);
    chk(a, 1'b0);
    rd(ADDR_STATUS, v);
    chk(v[BIT_DIRECTION], 1'b0);
    m_u.send(dd, a);
    chk(a, ctl[BIT_ACK_VALUE]);
    rd(ADDR_STATUS, v);
    chk(v[BIT_RX_FULL], 1'b1);
    rd(ADDR_RECEIVE, v);
    chk(v, {8'h00, dd});
    rd(ADDR_STATUS, v);
    chk(v[BIT_RX_FULL], 1'b0);
    m_u.stop();
    rd(ADDR_STATUS, v);
    chk(v[BIT_START_SEEN], 1'b0);
    chk(irq, 1'b1);
    rd(ADDR_IRQ_STAT, v);
    chk(v, 16'h000a);
    repeat (2) @(posedge clk);
    chk(irq, 1'b0);
  endtask
  // hung link or handshake ends the run
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      errors++;
      report_and_stop();
    end
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    void'($urandom(27));
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    rd(ADDR_CONTROL, v);
    chk(v, RESET_CONTROL);
    rd(ADDR_STATUS, v);
    chk(v, RESET_STATUS);
    rd(4'hf, v);
    chk(v, 16'h0000);
    chk(port_owns_pins, 1'b1);
    chk({pins.scl_o, pins.sda_o}, 2'b00);
    oa = 10'h008 + 10'($urandom % 112);
    wr(ADDR_OWN_ADDR, {6'h00, oa});
    wr(ADDR_IRQ_MASK, 16'h000f);
    setc(16'h9080);
    @(posedge clk);
    #1 chk(port_owns_pins, 1'b0);
    // sequence bits are not run here, so they drop at once
    wr(ADDR_CONTROL, ctl | 16'h001f);
    repeat (3) @(posedge clk);
    rd(ADDR_CONTROL, v);
    chk(v, ctl);
    for (int i = 0; i < 5; i++)
      write_xfer(i == 0 ? 8'h00 : i == 1 ? 8'hff : 8'($urandom));
    // foreign address: refused, then taken with acknowledge-all
    for (int i = 0; i < 2; i++)
    begin
      m_u.start();
      m_u.send({oa[6:0] ^ 7'h01, 1'b0}, a);
      chk(a, i == 0);
      m_u.stop();
      setc(ctl ^ 16'h0800);
    end
    // general call: masked first, then seen on the line
    wr(ADDR_IRQ_MASK, 16'h0000);
    m_u.start();
    m_u.send(GENCALL_ADDR, a);
    chk(a, 1'b0);
    m_u.stop();
    chk(irq, 1'b0);
    wr(ADDR_IRQ_MASK, 16'h0001);
    @(posedge clk);
    #1 chk(irq, 1'b1);
    rd(ADDR_IRQ_STAT, v);
    chk(v[IRQ_GENCALL], 1'b1);
    repeat (2) @(posedge clk);
    chk(irq, 1'b0);
    // slave transmit: clock held until software sets release
    d = 8'($urandom);
    wr(ADDR_TRANSMIT, {8'h00, d});
    rd(ADDR_STATUS, v);
    chk(v[BIT_TX_FULL], 1'b1);
    m_u.start();
    m_u.send({oa[6:0], 1'b1}, a);
    chk(a, 1'b0);
    rd(ADDR_STATUS, v);
    chk(v[BIT_DIRECTION], 1'b1);
    fork
      m_u.recv(1'b1, got);
      begin
        repeat (20) @(posedge clk);
        chk(scl_line, 1'b0);
        rd(ADDR_CONTROL, v);
        chk(v[BIT_RELEASE], 1'b0);
        // software only ever writes release as 1
        wr(ADDR_CONTROL, ctl);
      end
    join
    chk(got, d);
    m_u.stop();
    rd(ADDR_STATUS, v);
    chk(v[BIT_TX_FULL], 1'b0);
    // receive with stretching: held after the byte
    setc(ctl | 16'h0040);
    m_u.start();
    m_u.send({oa[6:0], 1'b0}, a);
    m_u.send(8'($urandom), a);
    fork
      m_u.stop();
      begin
        repeat (20) @(posedge clk);
        chk(scl_line, 1'b0);
        rd(ADDR_CONTROL, v);
        chk(v[BIT_RELEASE], 1'b0);
        wr(ADDR_CONTROL, ctl);
      end
    join
    rd(ADDR_RECEIVE, v);
    setc(ctl & ~16'h0040);
    // halted while idle: no answer on the wire
    setc(ctl | 16'h2000);
    device_idle <= 1'b1;
    m_u.start();
    m_u.send({oa[6:0], 1'b0}, a);
    chk(a, 1'b1);
    m_u.stop();
    device_idle <= 1'b0;
    // wide own address in two bytes
    oa = 10'($urandom);
    wr(ADDR_OWN_ADDR, {6'h00, oa});
    setc((ctl & ~16'h2000) | 16'h0400);
    m_u.start();
    m_u.send({5'b11110, oa[9:8], 1'b0}, a);
    chk(a, 1'b0);
    m_u.send(oa[7:0], a);
    chk(a, 1'b0);
    m_u.stop();
    chk(m_u.fails, 0);
    report_and_stop();
  end
endmodule
